// File: core/circ_pkg.sv
// Package with the register map, field positions, reset values and range points of the clock input slice.
package circ_pkg;
   // Byte offsets of the register map.
   localparam logic [6:0]  INPUT_CLOCK_CONFIG_ADDR     = 7'h2a;
   localparam logic [6:0]  SUPPLY_NOISE_CONFIG_ADDR    = 7'h2b;
   localparam logic [6:0]  REFERENCE_EDGE_POSITION_ADDR = 7'h2c;
   localparam logic [6:0]  FULL_SCALE_RANGE_ADDR       = 7'h30;
   localparam logic [6:0]  FULL_SCALE_RANGE_HI_ADDR    = 7'h31;
   localparam logic [6:0]  EDGE_POSITION_MID_ADDR      = 7'h2d;
   localparam logic [6:0]  EDGE_POSITION_HI_ADDR       = 7'h2e;
   localparam logic [6:0]  ALIGN_REF_CONTROL_ADDR      = 7'h29;
   // Reset values.
   localparam logic [7:0]  INPUT_CLOCK_CONFIG_RST  = 8'h00;
   localparam logic [7:0]  SUPPLY_NOISE_CONFIG_RST = 8'h10;
   localparam logic [7:0]  ALIGN_REF_CONTROL_RST   = 8'h80;
   localparam logic [15:0] FULL_SCALE_RANGE_RST    = 16'ha000;
   // Field positions.
   localparam int DEVICE_CLOCK_PECL_BIT   = 2;
   localparam int ALIGN_REF_PECL_BIT      = 1;
   localparam int ALIGN_REF_INVERT_BIT    = 0;
   localparam int QUIET_DENOISE_BIT       = 2;
   localparam int CLOCK_DENOISE_BIT       = 0;
   localparam int WINDOW_FINE_BIT         = 4;
   localparam int DELAY_SELECT_MSB        = 3;
   // Full-scale range points in code and millivolts peak to peak.
   localparam logic [15:0] FSR_CODE_LOW  = 16'h2000;
   localparam logic [15:0] FSR_CODE_MID  = 16'ha000;
   localparam logic [15:0] FSR_CODE_MAX  = 16'hffff;
   localparam logic [9:0]  FSR_MV_LOW    = 10'h1f4;
   localparam logic [9:0]  FSR_MV_MID    = 10'h320;
   localparam logic [9:0]  FSR_MV_MAX    = 10'h3e8;
endpackage

// File: core/circ_regs.sv
// Clock input, supply noise, edge position and full-scale range registers behind the serial control port.
// Operation
// - Input clock config resets to all zeros.
// - Bit 2 selects device clock PECL mode.
// - Bit 1 selects alignment reference PECL mode.
// - Bit 0 inverts the alignment reference.
// - Supply noise config resets to 0x10.
// - Bit 2 enables quiet analog supply denoise.
// - Bit 0 enables clock supply denoise.
// - Read-only 24-bit reference edge position.
// - 16-bit full-scale code, resets 0xA000.
// - Codes 0x2000/0xA000/0xFFFF give 500/800/1000 mV.
// - Four-bit field selects alignment sampling delay.
// - Fine bit shrinks windowing delay steps.
//
// Access model: the serial control port ahead of this block turns each transfer into
// byte strobes. A write strobe with clkEn high lands on that rising edge; the decoded
// control outputs follow on the next enabled edge. A read strobe loads regRdata on its
// edge and the byte then stands until the next read.
//
// Byte layout: the range code takes two consecutive addresses, low byte first, and the
// edge position takes three, least significant byte first. Each byte is written or
// read on its own; there is no shadow latch, so software that changes the range code
// sees one intermediate code between the two byte writes.
//
// Limitations: reserved bits are stored as written and read back as written. Keeping
// them at their defaults is left to software, which saves a per-bit mask here.
//
// Clocking: every flip-flop runs on clk and is frozen while clkEn is low. The
// reference pin and the edge position bus come from other timing domains and are
// resynchronised; only the edge position compare reads the first synchroniser stage directly.
`timescale 1ns/10ps
`default_nettype none
module circ_regs (
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        clkEn,
   input  wire logic        regWrite,
   input  wire logic        regRead,
   input  wire logic [6:0]  regAddr,
   input  wire logic [7:0]  regWdata,
   output logic      [7:0]  regRdata,
   input  wire logic        alignRefRaw,
   input  wire logic [23:0] edgePosition,
   output logic             deviceClockPeclMode,
   output logic             alignRefPeclMode,
   output logic             alignRefUsed,
   output logic             analogQuietSupplyDenoise,
   output logic             clockSupplyDenoise,
   output logic [3:0]       alignRefDelaySelect,
   output logic             alignRefWindowFine,
   output logic [15:0]      fullScaleRange,
   output logic [9:0]       fullScaleMillivolts
);
   logic [7:0]  inputClockConfig_reg;
   logic [7:0]  supplyNoiseConfig_reg;
   logic [7:0]  alignRefControl_reg;
   logic [15:0] fullScaleRange_reg;
   logic [1:0]  alignRefSync_reg;
   logic [23:0] edgePosSync1_reg;
   logic [23:0] edgePosSync2_reg;
   logic [23:0] edgePosHold_reg;
   logic [9:0]  fsrMv_next;

   ////////////////////////////////////////////////////////////////////////////////
   // Configuration writes; each register is a byte lane, the range code spans two bytes.
   // package default reset values
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         inputClockConfig_reg  <= circ_pkg::INPUT_CLOCK_CONFIG_RST;
         supplyNoiseConfig_reg <= circ_pkg::SUPPLY_NOISE_CONFIG_RST;
         alignRefControl_reg   <= circ_pkg::ALIGN_REF_CONTROL_RST;
         fullScaleRange_reg    <= circ_pkg::FULL_SCALE_RANGE_RST;
      end else if (clkEn && regWrite) begin
         // Reserved bits are stored as written; software is expected to keep them at default.
         unique case (regAddr)
            circ_pkg::INPUT_CLOCK_CONFIG_ADDR:  inputClockConfig_reg <= regWdata;
            circ_pkg::SUPPLY_NOISE_CONFIG_ADDR: supplyNoiseConfig_reg <= regWdata;
            circ_pkg::ALIGN_REF_CONTROL_ADDR:   alignRefControl_reg <= regWdata;
            circ_pkg::FULL_SCALE_RANGE_ADDR:    fullScaleRange_reg[7:0] <= regWdata;
            circ_pkg::FULL_SCALE_RANGE_HI_ADDR: fullScaleRange_reg[15:8] <= regWdata;
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Pin inputs pass two flip-flops; only the edge position compare also reads the first stage.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         alignRefSync_reg <= 2'h0;
         edgePosSync1_reg <= 24'h000000;
         edgePosSync2_reg <= 24'h000000;
      end else if (clkEn) begin
         alignRefSync_reg <= {alignRefSync_reg[0], alignRefRaw};
         edgePosSync1_reg <= edgePosition;
         edgePosSync2_reg <= edgePosSync1_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // The edge position bus is many bits wide, so two flip-flops alone could hand over a
   // mix of old and new bits while it changes. A snapshot is taken only when both
   // synchroniser stages agree, which means the bus has held still for a full cycle.
   // The trade-off is one more cycle of latency on a slowly changing status value.
   // coherent edge position
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         edgePosHold_reg <= 24'h000000;
      end else if (clkEn && (edgePosSync1_reg == edgePosSync2_reg)) begin
         edgePosHold_reg <= edgePosSync2_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Piecewise linear map from code to millivolts, monotonic between the listed points.
   // Products are formed at 32 bits, because a 16-bit code times a slope needs up to 24 bits;
   // a 16-bit product would overflow and fold the map back on itself.
   // listed points
   always_comb begin
      logic [31:0] span;
      span = 32'h00000000;
      fsrMv_next = circ_pkg::FSR_MV_MID;
      if (fullScaleRange_reg < circ_pkg::FSR_CODE_LOW) begin
         // Below the recommended minimum the range keeps shrinking linearly toward zero.
         span = (32'(fullScaleRange_reg) * 32'(circ_pkg::FSR_MV_LOW)) / 32'(circ_pkg::FSR_CODE_LOW);
         fsrMv_next = span[9:0];
      end else if (fullScaleRange_reg < circ_pkg::FSR_CODE_MID) begin
         span = (32'(fullScaleRange_reg - circ_pkg::FSR_CODE_LOW)
                 * 32'(circ_pkg::FSR_MV_MID - circ_pkg::FSR_MV_LOW))
                / 32'(circ_pkg::FSR_CODE_MID - circ_pkg::FSR_CODE_LOW);
         fsrMv_next = circ_pkg::FSR_MV_LOW + span[9:0];
      end else begin
         span = (32'(fullScaleRange_reg - circ_pkg::FSR_CODE_MID)
                 * 32'(circ_pkg::FSR_MV_MAX - circ_pkg::FSR_MV_MID))
                / 32'(circ_pkg::FSR_CODE_MAX - circ_pkg::FSR_CODE_MID);
         fsrMv_next = circ_pkg::FSR_MV_MID + span[9:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Control outputs are registered so the analog side sees clean levels.
   // device clock PECL
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         deviceClockPeclMode      <= 1'b0;
         alignRefPeclMode         <= 1'b0;
         alignRefUsed             <= 1'b0;
         analogQuietSupplyDenoise <= 1'b0;
         clockSupplyDenoise       <= 1'b0;
         alignRefDelaySelect      <= 4'h0;
         alignRefWindowFine       <= 1'b0;
         fullScaleRange           <= circ_pkg::FULL_SCALE_RANGE_RST;
         fullScaleMillivolts      <= circ_pkg::FSR_MV_MID;
      end else if (clkEn) begin
         deviceClockPeclMode      <= inputClockConfig_reg[circ_pkg::DEVICE_CLOCK_PECL_BIT];
         alignRefPeclMode         <= inputClockConfig_reg[circ_pkg::ALIGN_REF_PECL_BIT];
         alignRefUsed             <= alignRefSync_reg[1] ^ inputClockConfig_reg[circ_pkg::ALIGN_REF_INVERT_BIT];
         analogQuietSupplyDenoise <= supplyNoiseConfig_reg[circ_pkg::QUIET_DENOISE_BIT];
         clockSupplyDenoise       <= supplyNoiseConfig_reg[circ_pkg::CLOCK_DENOISE_BIT];
         alignRefDelaySelect      <= alignRefControl_reg[circ_pkg::DELAY_SELECT_MSB:0];
         alignRefWindowFine       <= alignRefControl_reg[circ_pkg::WINDOW_FINE_BIT];
         fullScaleRange           <= fullScaleRange_reg;
         fullScaleMillivolts      <= fsrMv_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Read data, registered on the edge that takes the read strobe; unmapped bytes read zero.
   // edge position readback
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         regRdata <= 8'h00;
      end else if (clkEn && regRead) begin
         unique case (regAddr)
            circ_pkg::ALIGN_REF_CONTROL_ADDR:       regRdata <= alignRefControl_reg;
            circ_pkg::INPUT_CLOCK_CONFIG_ADDR:      regRdata <= inputClockConfig_reg;
            circ_pkg::SUPPLY_NOISE_CONFIG_ADDR:     regRdata <= supplyNoiseConfig_reg;
            circ_pkg::REFERENCE_EDGE_POSITION_ADDR: regRdata <= edgePosHold_reg[7:0];
            circ_pkg::EDGE_POSITION_MID_ADDR:       regRdata <= edgePosHold_reg[15:8];
            circ_pkg::EDGE_POSITION_HI_ADDR:        regRdata <= edgePosHold_reg[23:16];
            circ_pkg::FULL_SCALE_RANGE_ADDR:        regRdata <= fullScaleRange_reg[7:0];
            circ_pkg::FULL_SCALE_RANGE_HI_ADDR:     regRdata <= fullScaleRange_reg[15:8];
            default:                                regRdata <= 8'h00;
         endcase
      end
   end
endmodule
`default_nettype wire

// File: sim/circ_regs_asserts.sv
// Concurrent checks on the register slice ports.
`timescale 1ns/10ps
`default_nettype none
module circ_regs_asserts (
   input wire logic        clk,
   input wire logic        reset,
   input wire logic        clkEn,
   input wire logic        regWrite,
   input wire logic [6:0]  regAddr,
   input wire logic [7:0]  regWdata,
   input wire logic        alignRefRaw,
   input wire logic        deviceClockPeclMode,
   input wire logic        alignRefPeclMode,
   input wire logic        alignRefUsed,
   input wire logic        analogQuietSupplyDenoise,
   input wire logic        clockSupplyDenoise,
   input wire logic [15:0] fullScaleRange,
   input wire logic [9:0]  fullScaleMillivolts
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   logic [6:0] wa;
   logic       invBit;
   // Address of a taken write, else an unmapped code.
   assign wa = (regWrite && clkEn) ? regAddr : 7'h7f;
   // Mirror of the invert bit, so the reference path is judged from the port side alone.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) invBit <= 1'b0;
      else if (wa == 7'h2a) invBit <= regWdata[0];
   end
   // A write shows at the outputs two edges later unless the clock enable froze it.
   a_dev_pecl: assert property (wa == 7'h2a ##1 clkEn |-> ##1 deviceClockPeclMode == $past(regWdata[2], 2))
      else $error("Device clock mode wrong.");
   a_ref_pecl: assert property (wa == 7'h2a ##1 clkEn |-> ##1 alignRefPeclMode == $past(regWdata[1], 2))
      else $error("Reference mode wrong.");
   a_ref_invert: assert property ((clkEn && wa != 7'h2a && $stable(alignRefRaw))[*6] |-> alignRefUsed == (alignRefRaw ^ invBit))
      else $error("Reference polarity wrong.");
   a_quiet_denoise: assert property (wa == 7'h2b ##1 clkEn |-> ##1 analogQuietSupplyDenoise == $past(regWdata[2], 2))
      else $error("Quiet supply enable wrong.");
   a_clock_denoise: assert property (wa == 7'h2b ##1 clkEn |-> ##1 clockSupplyDenoise == $past(regWdata[0], 2))
      else $error("Clock supply enable wrong.");
   a_range_low: assert property (wa == 7'h30 ##1 clkEn |-> ##1 fullScaleRange[7:0] == $past(regWdata, 2))
      else $error("Range low byte wrong.");
   a_range_high: assert property (wa == 7'h31 ##1 clkEn |-> ##1 fullScaleRange[15:8] == $past(regWdata, 2))
      else $error("Range high byte wrong.");
   a_mv_low: assert property ($stable(fullScaleRange)[*2] ##0 fullScaleRange == 16'h2000 |-> fullScaleMillivolts == 10'h1f4)
      else $error("Low range point wrong.");
   a_mv_top: assert property ($stable(fullScaleRange)[*2] ##0 fullScaleRange == 16'hffff |-> fullScaleMillivolts == 10'h3e8)
      else $error("Top range point wrong.");
   // Main scenarios reached.
   cover property (wa == 7'h2a ##1 clkEn);
   cover property (wa == 7'h31 ##1 clkEn);
   cover property (alignRefUsed && invBit);
endmodule
`default_nettype wire

// File: sim/circ_regs_tb.sv
// Self-checking bench for the clock input and range register slice.
`timescale 1ns/10ps
`default_nettype none
module clock_input_and_range_config_regs_tb;
   logic        clk = 1'b0, reset = 1'b1, clkEn = 1'b1, regWrite = 1'b0, regRead = 1'b0, alignRefRaw = 1'b1;
   logic [6:0]  regAddr = 7'h00;
   logic [7:0]  regWdata = 8'h00, regRdata;
   logic [23:0] edgePosition = 24'h5a3c81;
   logic        deviceClockPeclMode, alignRefPeclMode, alignRefUsed, analogQuietSupplyDenoise, clockSupplyDenoise;
   logic        alignRefWindowFine;
   logic [3:0]  alignRefDelaySelect;
   logic [15:0] fullScaleRange, codes [4] = '{16'h2000, 16'h6000, 16'ha000, 16'hffff};
   logic [9:0]  fullScaleMillivolts, mvs [4] = '{10'h1f4, 10'h28a, 10'h320, 10'h3e8};
   int          mismatches = 0, compares = 0;
   circ_regs dut (.clk, .reset, .clkEn, .regWrite, .regRead, .regAddr, .regWdata, .regRdata, .alignRefRaw,
      .edgePosition, .deviceClockPeclMode, .alignRefPeclMode, .alignRefUsed, .analogQuietSupplyDenoise,
      .clockSupplyDenoise, .alignRefDelaySelect, .alignRefWindowFine, .fullScaleRange, .fullScaleMillivolts);
   // Free-running 50 MHz clock.
   always #10 clk = ~clk;
   // Counted comparison; narrow values are zero extended so an unknown never matches.
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One-cycle strobe then an idle cycle, so no strobe is set twice in one time step.
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      regAddr = a;
      regWdata = d;
      regWrite = 1'b1;
      @(negedge clk) regWrite = 1'b0;
      @(negedge clk);
   endtask
   // The read byte is registered on the taking edge.
   task automatic rd(input logic [6:0] a, input logic [7:0] e);
      regAddr = a;
      regRead = 1'b1;
      @(negedge clk) regRead = 1'b0;
      chk(regRdata, e);
      @(negedge clk);
   endtask
   task automatic test_done;
      if (mismatches == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // Main access sequence; every wait is a fixed count from the hand-over latencies.
   initial begin
      repeat (3) @(negedge clk);
      reset = 1'b0;
      @(negedge clk);
      rd(7'h2a, 8'h00);
      rd(7'h2b, 8'h10);
      rd(7'h31, 8'ha0);
      chk(fullScaleMillivolts, 10'h320);
      rd(7'h40, 8'h00);
      chk(alignRefUsed, 1'b1);
      rd(7'h2c, 8'h81);
      rd(7'h2e, 8'h5a);
      wr(7'h2d, 8'hff);
      rd(7'h2d, 8'h3c);
      wr(7'h2a, 8'h07);
      repeat (4) @(negedge clk);
      chk({deviceClockPeclMode, alignRefPeclMode, alignRefUsed}, 3'b110);
      wr(7'h2b, 8'h15);
      wr(7'h29, 8'h9a);
      chk({analogQuietSupplyDenoise, clockSupplyDenoise, alignRefWindowFine, alignRefDelaySelect}, 7'h7a);
      clkEn = 1'b0;
      wr(7'h2a, 8'h00);
      clkEn = 1'b1;
      rd(7'h2a, 8'h07);
      for (int i = 0; i < 4; i++) begin
         wr(7'h30, codes[i][7:0]);
         wr(7'h31, codes[i][15:8]);
         repeat (3) @(negedge clk);
         chk(fullScaleRange, codes[i]);
         chk(fullScaleMillivolts, mvs[i]);
      end
      // Mid-run reset must bring input clock config, the range code and the mode outputs back to their defaults.
      reset = 1'b1;
      repeat (2) @(negedge clk);
      reset = 1'b0;
      @(negedge clk);
      rd(7'h2a, 8'h00);
      rd(7'h30, 8'h00);
      chk(fullScaleRange, 16'ha000);
      chk({deviceClockPeclMode, alignRefPeclMode, alignRefUsed}, 3'b001);
      test_done;
   end
endmodule
bind circ_regs circ_regs_asserts u_chk (.clk, .reset, .clkEn, .regWrite, .regAddr, .regWdata, .alignRefRaw,
   .deviceClockPeclMode, .alignRefPeclMode, .alignRefUsed, .analogQuietSupplyDenoise, .clockSupplyDenoise,
   .fullScaleRange, .fullScaleMillivolts);
`default_nettype wire
